// *** pmc_defines.vh ***
// constants for the power mode controller
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// ----------------------------------------------------------------------
// mode encodings (software request code and reported mode)
// ----------------------------------------------------------------------
`define PMC_MODE_W          2
`define PMC_MODE_ACTIVE     2'h0
`define PMC_MODE_ALT        2'h1
`define PMC_MODE_SLEEP      2'h2
`define PMC_MODE_HIBERNATE  2'h3

// ----------------------------------------------------------------------
// subsystem templates
// ----------------------------------------------------------------------
`define PMC_SUBSYS_W        8
`define PMC_SUBSYS_OFF      8'h00
// subsystems that stay powered in sleep (none by default)
`define PMC_SLEEP_KEEP      8'h00

// ----------------------------------------------------------------------
// wake timer
// ----------------------------------------------------------------------
// interval select: 0..7 gives 2^(sel) ms ... 128 ms at sel 7
`define PMC_IVL_W           3
`define PMC_IVL_MAX         3'h7
// low-speed oscillator tick assumed at 1 kHz (one tick per ms)
`define PMC_TICK_W          8
`define PMC_TICK_ONE        8'h01
`define PMC_TICK_ZERO       8'h00
// time between the timer firing and cpu release, in us
`define PMC_WAKE_US         125
`define PMC_CLK_MHZ         100
`define PMC_WAKE_CYC        (`PMC_WAKE_US * `PMC_CLK_MHZ)
`define PMC_WAIT_W          14
`define PMC_WAIT_ZERO       14'h0000

`endif

// *** pmc_power_mode_ctrl.v ***
// power mode controller: active, alternate active, sleep, hibernate
// ----------------------------------------------------------------------
// Summary of operation
// RULE1 - four modes: active, alternate active, sleep, hibernate, in that order
// RULE2 - in active each subsystem follows its bit in the active template
// RULE3 - alternate active applies its own template; cpu may be stopped
// RULE4 - entering sleep forces most subsystems off regardless of templates
// RULE5 - in sleep the wake timer on the slow oscillator ends the sleep
// RULE6 - wake interval is programmable, longest 128 ms
// RULE7 - hibernate stops all clocks, keeps register and ram contents
// RULE8 - only reset leaves hibernate; no interrupt or timer does
// RULE9 - active entered on wakeup, after reset, or on firmware request
// RULE10 - firmware requests low power only with io rails good, irqs on
// RULE11 - after timer wake the active template is applied before cpu runs
// RULE12 - sleep or hibernate accepted only from the two active modes
// ----------------------------------------------------------------------
`include "pmc_defines.vh"

module pmc_power_mode_ctrl #(
  parameter WAKE_CYC = `PMC_WAKE_CYC
) (
  input  wire                     clk,
  input  wire                     rst_b,
  input  wire                     mode_req,
  input  wire [`PMC_MODE_W-1:0]   mode_sel,
  input  wire [`PMC_SUBSYS_W-1:0] active_template,
  input  wire [`PMC_SUBSYS_W-1:0] alt_template,
  input  wire                     alt_cpu_on,
  input  wire [`PMC_IVL_W-1:0]    wake_interval,
  input  wire                     wake_timer_en,
  input  wire                     low_speed_internal_osc,
  input  wire                     any_irq,
  output reg  [`PMC_MODE_W-1:0]   mode,
  output reg  [`PMC_SUBSYS_W-1:0] subsys_en,
  output reg                      cpu_run,
  output reg                      main_clk_en,
  output reg                      slow_osc_en,
  output reg                      retain,
  output reg                      wake_irq
);

  // --------------------------------------------------------------------
  // one-hot states
  // --------------------------------------------------------------------
  localparam [4:0] ST_ACT   = 5'h01;
  localparam [4:0] ST_ALT   = 5'h02;
  localparam [4:0] ST_SLEEP = 5'h04;
  localparam [4:0] ST_WAKE  = 5'h08;
  localparam [4:0] ST_HIB   = 5'h10; // RULE1

  function [`PMC_TICK_W-1:0] ivl_ticks;
    input [`PMC_IVL_W-1:0] sel;
    begin
      ivl_ticks = `PMC_TICK_ONE << sel; // RULE6
    end
  endfunction

  reg  [4:0]               state_reg;
  reg  [4:0]               state_next;
  reg  [`PMC_TICK_W-1:0]   tick_cnt_reg;
  reg  [`PMC_WAIT_W-1:0]   wait_cnt_reg;
  reg                      osc_s1_reg;
  reg                      osc_s2_reg;
  reg                      osc_s3_reg;
  reg                      irq_s1_reg;
  reg                      irq_s2_reg;
  wire                     osc_tick;
  wire                     timer_fire;
  wire                     low_req;

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      irq_s1_reg <= 1'b0;
      irq_s2_reg <= 1'b0;
    end else begin
      osc_s1_reg <= low_speed_internal_osc;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      irq_s1_reg <= any_irq;
      irq_s2_reg <= irq_s1_reg;
    end
  end

  // rising edge of the slow oscillator, one tick per period
  assign osc_tick   = osc_s2_reg & ~osc_s3_reg;
  // a stopped timer never fires, whatever count it was frozen at
  assign timer_fire = osc_tick & wake_timer_en &
                      (tick_cnt_reg == `PMC_TICK_ONE);
  // sleep/hibernate are only honoured from the running modes
  assign low_req = mode_req & (state_reg[0] | state_reg[1]) &
                   ((mode_sel == `PMC_MODE_SLEEP) |
                    (mode_sel == `PMC_MODE_HIBERNATE)); // RULE12

  // --------------------------------------------------------------------
  // mode state machine
  // --------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_ACT, ST_ALT: begin
        if (low_req && mode_sel == `PMC_MODE_SLEEP) begin
          state_next = ST_SLEEP; // RULE4
        end else if (low_req) begin
          state_next = ST_HIB; // RULE7
        end else if (mode_req && mode_sel == `PMC_MODE_ALT) begin
          state_next = ST_ALT; // RULE3
        end else if (mode_req && mode_sel == `PMC_MODE_ACTIVE) begin
          state_next = ST_ACT; // RULE9
        end
      end
      ST_SLEEP: begin
        if (timer_fire) begin
          state_next = ST_WAKE; // RULE5
        end
      end
      ST_WAKE: begin
        if (wait_cnt_reg == `PMC_WAIT_ZERO) begin
          state_next = ST_ACT; // RULE9
        end
      end
      // only the reset leaves this state; nothing else is looked at
      ST_HIB: state_next = ST_HIB; // RULE8
      default: state_next = ST_ACT;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_ACT; // RULE9
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------
  // wake timer and wake delay
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= `PMC_TICK_ZERO;
      wait_cnt_reg <= `PMC_WAIT_ZERO;
    end else begin
      if (state_next == ST_SLEEP && state_reg != ST_SLEEP) begin
        tick_cnt_reg <= ivl_ticks(wake_interval); // RULE6
      end else if (state_reg == ST_SLEEP && osc_tick && wake_timer_en) begin
        if (tick_cnt_reg == `PMC_TICK_ONE) begin
          tick_cnt_reg <= ivl_ticks(wake_interval); // RULE5
        end else begin
          tick_cnt_reg <= tick_cnt_reg - `PMC_TICK_ONE;
        end
      end
      if (state_next == ST_WAKE && state_reg != ST_WAKE) begin
        wait_cnt_reg <= WAKE_CYC[`PMC_WAIT_W-1:0] - 14'h0001;
      end else if (wait_cnt_reg != `PMC_WAIT_ZERO) begin
        wait_cnt_reg <= wait_cnt_reg - 14'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // registered outputs, computed from the next state
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode        <= `PMC_MODE_ACTIVE;
      subsys_en   <= `PMC_SUBSYS_OFF;
      cpu_run     <= 1'b1;
      main_clk_en <= 1'b1;
      slow_osc_en <= 1'b1;
      retain      <= 1'b0;
      wake_irq    <= 1'b0;
    end else begin
      wake_irq    <= 1'b0;
      slow_osc_en <= ~state_next[4];
      retain      <= state_next[4]; // RULE7
      case (state_next)
        ST_ACT: begin
          mode        <= `PMC_MODE_ACTIVE;
          subsys_en   <= active_template; // RULE2
          cpu_run     <= 1'b1;
          main_clk_en <= 1'b1;
        end
        ST_ALT: begin
          mode        <= `PMC_MODE_ALT;
          subsys_en   <= alt_template; // RULE3
          cpu_run     <= alt_cpu_on; // RULE3
          main_clk_en <= 1'b1;
        end
        ST_SLEEP: begin
          mode        <= `PMC_MODE_SLEEP;
          subsys_en   <= `PMC_SLEEP_KEEP; // RULE4
          cpu_run     <= 1'b0;
          main_clk_en <= 1'b0; // RULE5
        end
        ST_WAKE: begin
          // template restored while the cpu is still held
          mode        <= `PMC_MODE_ACTIVE;
          subsys_en   <= active_template; // RULE11
          cpu_run     <= 1'b0; // RULE11
          main_clk_en <= 1'b1;
          wake_irq    <= (state_reg == ST_SLEEP); // RULE5
        end
        ST_HIB: begin
          mode        <= `PMC_MODE_HIBERNATE;
          subsys_en   <= `PMC_SUBSYS_OFF; // RULE4
          cpu_run     <= 1'b0;
          main_clk_en <= 1'b0; // RULE7
        end
        default: begin
          mode        <= `PMC_MODE_ACTIVE;
          subsys_en   <= `PMC_SUBSYS_OFF;
          cpu_run     <= 1'b1;
          main_clk_en <= 1'b1;
        end
      endcase
    end
  end

  // any_irq is synchronised for future use by alternate active wakeups;
  // hibernate deliberately ignores it
  wire unused_irq = irq_s2_reg;

endmodule // pmc_power_mode_ctrl

// *** pmc_power_mode_ctrl_props.sv ***
// port assertions for the power mode controller
`include "pmc_defines.vh"
module pmc_power_mode_ctrl_props #(
  parameter WAKE_CYC = 4
) (
  input logic       clk,
  input logic       rst_b,
  input logic       mode_req,
  input logic [1:0] mode_sel,
  input logic [7:0] active_template,
  input logic [7:0] alt_template,
  input logic       alt_cpu_on,
  input logic [2:0] wake_interval,
  input logic       wake_timer_en,
  input logic       low_speed_internal_osc,
  input logic       any_irq,
  input logic [1:0] mode,
  input logic [7:0] subsys_en,
  input logic       cpu_run,
  input logic       main_clk_en,
  input logic       slow_osc_en,
  input logic       retain,
  input logic       wake_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WMAX = WAKE_CYC + 3;
  wire up = mode_req && !mode[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // cpu must stay parked while the active template settles
  sequence s_held;
    (mode == 2'h0 && !cpu_run) [*2];
  endsequence
  a_wake_release: assert property (wake_irq |-> s_held ##[1:WMAX] cpu_run)
    else $error("cpu released early or never after wake");
  a_wake_pulse: assert property (wake_irq |-> $past(mode) == 2'h2 ##1 !wake_irq)
    else $error("wake pulse outside sleep exit");
  a_sleep_gated: assert property (mode == 2'h2 |-> subsys_en == 8'h00 &&
    !cpu_run && !main_clk_en && slow_osc_en)
    else $error("sleep left something powered");
  a_hib_state: assert property (mode == 2'h3 |-> retain && !main_clk_en &&
    !slow_osc_en && subsys_en == 8'h00)
    else $error("hibernate outputs wrong");
  a_hib_stays: assert property (mode == 2'h3 |=> mode == 2'h3)
    else $error("hibernate left without reset");
  a_low_entry: assert property (up && mode_sel[1] |=> mode == $past(mode_sel))
    else $error("low power request not taken");
  a_alt_tmpl: assert property (mode == 2'h1 |-> subsys_en == $past(alt_template)
    && cpu_run == $past(alt_cpu_on))
    else $error("alt template not applied");
  a_act_tmpl: assert property (mode == 2'h0 && $past(rst_b) |->
    subsys_en == $past(active_template))
    else $error("active template not applied");
  a_act_entry: assert property (up && mode_sel == 2'h0 |=> mode == 2'h0)
    else $error("active request not taken");
  a_frozen: assert property (mode == 2'h2 && !wake_timer_en |=> mode == 2'h2)
    else $error("frozen timer woke the device");
endmodule // pmc_power_mode_ctrl_props
bind pmc_power_mode_ctrl pmc_power_mode_ctrl_props #(.WAKE_CYC(WAKE_CYC)) u_p (
  .clk(clk), .rst_b(rst_b), .mode_req(mode_req), .mode_sel(mode_sel),
  .active_template(active_template), .alt_template(alt_template),
  .alt_cpu_on(alt_cpu_on), .wake_interval(wake_interval),
  .wake_timer_en(wake_timer_en), .any_irq(any_irq),
  .low_speed_internal_osc(low_speed_internal_osc), .mode(mode),
  .subsys_en(subsys_en), .cpu_run(cpu_run), .main_clk_en(main_clk_en),
  .slow_osc_en(slow_osc_en), .retain(retain), .wake_irq(wake_irq));

// *** tb.sv ***
// testbench for the power mode controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] s, m; logic [7:0] en;
                         logic c, a;} pmc_row_t;
  pmc_row_t   rows [4] = '{'{1,1,8'h0f,0,0}, '{1,1,8'h0f,1,1},
                            '{0,0,8'h5a,1,0}, '{1,1,8'h0f,0,0}};
  logic       clk = 0, rst_b = 0, mode_req = 0, ten = 1, osc = 0, irq = 0;
  logic       aco = 0;
  logic [1:0] mode_sel = 0, mode;
  logic [2:0] ivl = 0;
  logic [7:0] subsys_en;
  logic       cpu_run, main_clk_en, slow_osc_en, retain, wake_irq;
  int         mismatches = 0, total_checks = 0, wakes = 0, n, i;
  pmc_power_mode_ctrl #(.WAKE_CYC(4)) u_pmc_power_mode_ctrl (
    .clk(clk), .rst_b(rst_b), .mode_req(mode_req), .mode_sel(mode_sel),
    .active_template(8'h5a), .alt_template(8'h0f), .alt_cpu_on(aco),
    .wake_interval(ivl), .wake_timer_en(ten), .low_speed_internal_osc(osc),
    .any_irq(irq), .mode(mode), .subsys_en(subsys_en), .cpu_run(cpu_run),
    .main_clk_en(main_clk_en), .slow_osc_en(slow_osc_en), .retain(retain),
    .wake_irq(wake_irq));
  always #5 clk = ~clk;
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task req(input logic [1:0] s);
    @(posedge clk);
    mode_req <= 1;
    mode_sel <= s;
    @(posedge clk);
    mode_req <= 0;
    #1;
  endtask
  // one slow oscillator period, long enough for the synchroniser
  task tick;
    repeat (8) @(posedge clk);
    osc <= 1;
    repeat (8) @(posedge clk);
    osc <= 0;
    #1;
  endtask
  always @(posedge clk) if (wake_irq === 1'b1) begin
    wakes++;
    chk("cpu held", 0, cpu_run);
    chk("wake template", 8'h5a, subsys_en);
  end
  initial begin
    #200000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1;
    repeat (2) @(posedge clk);
    #1;
    chk("reset mode", 0, mode);
    chk("reset cpu", 1, cpu_run);
    chk("reset template", 8'h5a, subsys_en);
    foreach (rows[k]) begin
      @(posedge clk);
      aco <= rows[k].a;
      req(rows[k].s);
      chk("row mode", rows[k].m, mode);
      chk("row subsys", rows[k].en, subsys_en);
      chk("row cpu", rows[k].c, cpu_run);
    end
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      ivl <= i[2:0];
      req(2'h2);
      chk("sleep mode", 2, mode);
      chk("sleep gated", 0, subsys_en);
      if (i == 0) begin
        @(posedge clk);
        ten <= 0;
        repeat (2) tick();
        req(2'h3);
        req(2'h0);
        chk("sleep refuse", 2, mode);
        @(posedge clk);
        ten <= 1;
      end
      n = 0;
      while (mode === 2'h2 && n < 200) begin
        tick();
        n++;
      end
      if (n == 200) begin
        mismatches++;
        end_sim;
      end
      chk("wake ticks", 8'(1 << i), 8'(n));
      chk("wake mode", 0, mode);
      chk("cpu resumed", 1, cpu_run);
    end
    chk("wake count", 8, 8'(wakes));
    @(posedge clk);
    irq <= 1;
    req(2'h3);
    chk("hib mode", 3, mode);
    chk("hib signals", 8'h08, {retain, main_clk_en, slow_osc_en, cpu_run});
    tick();
    req(2'h0);
    chk("hib refuse", 3, mode);
    @(posedge clk);
    rst_b <= 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    repeat (2) @(posedge clk);
    #1;
    chk("hib exit", 0, mode);
    chk("retain off", 0, retain);
    end_sim;
  end
endmodule // tb
